// ### src/mosc_mode_ctrl.sv
/*
  Controller mode selection and output state control with an APB slave.
  Assumes a single 125 MHz clock, a synchronous reset, and a scan strobe
  from the scan sequencer on the same clock; the mode switch is a pin.
*/
//
// Contract
// R1: RUN drives all physical outputs from function block results.
// R2: RUN shows force indications on module status LEDs.
// R3: PROGRAM keeps scanning, stops blocks, forces all outputs off.
// R4: Firmware download is accepted only in PROGRAM, locked or not.
// R5: PROGRAM suppresses force indications on module status LEDs.
// R6: OFFLINE keeps scanning, stops blocks, holds outputs captured on entry.
// R7: OFFLINE allows analog input calibration, forces LEDs, refuses output calibration.
// R8: OFFLINE keeps diagnostics monitoring on local and expansion racks.
// R9: Off state drives discrete outputs low.
// R10: Off state runs time-proportioned outputs at zero duty.
// R11: Off state deasserts forward and reverse of each step pair.
// R12: Off state commands analog outputs to zero current.
// R13: Frozen state holds discrete outputs at last active level.
// R14: Frozen state keeps time-proportioned outputs at last duty.
// R15: Frozen state deasserts forward and reverse so motors hold.
// R16: Frozen state holds analog outputs at last current.
// R17: OFFLINE is entered only from RUN.
// R18: Switch position overrides operator interface selection.
// R19: Mode changes and freeze capture occur at a scan boundary.
`timescale 1ns/100ps
`default_nettype none
`include "mosc_regs.svh"

module mosc_mode_ctrl
  import mosc_pkg::*;
#(
  parameter int N_DO = 8,   // Discrete outputs.
  parameter int N_TP = 4,   // Time-proportioned outputs.
  parameter int N_ST = 2,   // Step output pairs.
  parameter int N_AO = 4    // Analog current outputs.
) (
  input  wire logic                 ref_clk,       // Clock, 125 MHz.
  input  wire logic                 reset,         // Synchronous reset, high.
  input  wire logic                 psel,          // APB select.
  input  wire logic                 penable,       // APB enable.
  input  wire logic                 pwrite,        // APB direction.
  input  wire logic [11:0]          paddr,         // APB byte address.
  input  wire logic [31:0]          pwdata,        // APB write data.
  output logic [31:0]               prdata,        // APB read data.
  output logic                      pready,        // APB ready.
  output logic                      pslverr,       // APB error.
  input  wire logic [1:0]           modeSwitch,    // Mode switch pin.
  input  wire logic                 scanEnd,       // Scan boundary pulse.
  input  wire logic                 forceActive,   // Forces present.
  input  wire logic [N_DO-1:0]      fbDout,        // Block discrete results.
  input  wire logic [N_TP*8-1:0]    fbDuty,        // Block duty results.
  input  wire logic [N_ST-1:0]      fbFwd,         // Block forward drive.
  input  wire logic [N_ST-1:0]      fbRev,         // Block reverse drive.
  input  wire logic [N_AO*16-1:0]   fbAout,        // Block analog results.
  output mosc_pkg::mosc_mode_t      modeOut,       // Active mode.
  output logic                      ioScanEn,      // I/O scanning enabled.
  output logic                      fbExecEn,      // Block execution enabled.
  output logic                      diagEn,        // Diagnostics monitoring.
  output logic                      forceLed,      // Force indication to LEDs.
  output logic                      fwDownloadEn,  // Firmware download allowed.
  output logic                      aiCalEn,       // Analog input cal allowed.
  output logic                      aoCalEn,       // Analog output cal allowed.
  output logic [N_DO-1:0]           dout,          // Discrete outputs.
  output logic [N_TP*8-1:0]         tpDuty,        // Time-proportioned duty.
  output logic [N_ST-1:0]           stepFwd,       // Step forward lines.
  output logic [N_ST-1:0]           stepRev,       // Step reverse lines.
  output logic [N_AO*16-1:0]        aout           // Analog current commands.
);
  import mosc_pkg::*;

  // ****************************************************************
  // Switch synchroniser.
  // ****************************************************************
  logic [1:0] swMeta_ff;
  logic [1:0] swSync_ff;

  // Two stages before any logic reads the switch.
  // Both stages reset to the program lock position, so that a scan boundary
  // right after reset cannot read a false run lock before the pin arrives.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      swMeta_ff <= `MOSC_SW_PROGLOCK;
      swSync_ff <= `MOSC_SW_PROGLOCK;
    end else begin
      swMeta_ff <= modeSwitch;
      swSync_ff <= swMeta_ff;
    end
  end

  // ****************************************************************
  // APB register file.
  // ****************************************************************
  logic [31:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  wire  logic  apbAcc  = psel & penable;
  wire  logic  apbWr   = apbAcc & pwrite;
  wire  logic  hitCtrl = (paddr == `MOSC_CTRL_OFS);
  wire  logic  hitStat = (paddr == `MOSC_STATUS_OFS);
  wire  logic  hitDout = (paddr == `MOSC_DOUT_OFS);
  wire  logic  hitDuty = (paddr == `MOSC_TPDUTY_OFS);
  wire  logic  hitStep = (paddr == `MOSC_STEP_OFS);
  wire  logic  hitAout = (paddr == `MOSC_AOUT_OFS);
  wire  logic  hitAny  = hitCtrl | hitStat | hitDout | hitDuty | hitStep | hitAout;

  mosc_mode_t mode_ff;
  logic [31:0] statusWord;
  logic [31:0] rdMux;

  // Status shows mode, switch and permission flags.
  assign statusWord = {24'h00_0000, aoCalEn, aiCalEn, fwDownloadEn, forceLed,
                       swSync_ff, 2'(mode_ff)};

  // Read selection, unmapped addresses read zero.
  assign rdMux = hitCtrl ? ctrl_ff :
                 hitStat ? statusWord :
                 hitDout ? 32'(dout) :
                 hitDuty ? 32'(tpDuty) :
                 hitStep ? 32'({stepRev, stepFwd}) :
                 hitAout ? 32'(aout) : 32'h0000_0000;

  // Zero wait states; unmapped access answers with an error.
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  // Register write and read data capture.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ff    <= `MOSC_CTRL_RST;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      if (apbWr && hitCtrl) ctrl_ff <= {27'h000_0000, pwdata[4:0]};
      prdata_ff  <= (psel && !penable && !pwrite) ? rdMux : prdata_ff;
      pslverr_ff <= psel && !penable && !hitAny;
    end
  end

  // ****************************************************************
  // Mode resolution.
  // ****************************************************************
  wire logic [1:0] opReq = ctrl_ff[`MOSC_CTRL_REQ_MSB:`MOSC_CTRL_REQ_LSB];
  mosc_mode_t reqMode;
  mosc_mode_t nxt_mode;

  // Switch locks override the operator request.
  always_comb begin
    case (swSync_ff)
      `MOSC_SW_RUNLOCK:  reqMode = MOSC_RUN;         // R18
      `MOSC_SW_PROGLOCK: reqMode = MOSC_PROGRAM;     // R18
      default: begin
        case (opReq)
          `MOSC_CODE_RUN:     reqMode = MOSC_RUN;
          `MOSC_CODE_OFFLINE: reqMode = MOSC_OFFLINE;
          default:            reqMode = MOSC_PROGRAM;
        endcase
      end
    endcase
  end

  // OFFLINE only from RUN; otherwise stay put.
  assign nxt_mode = (reqMode == MOSC_OFFLINE && mode_ff != MOSC_RUN &&
                     mode_ff != MOSC_OFFLINE) ? mode_ff : reqMode;  // R17

  // Mode applies at the scan boundary only.
  always_ff @(posedge ref_clk) begin
    if (reset) mode_ff <= MOSC_PROGRAM;
    else if (scanEnd) mode_ff <= nxt_mode;  // R19
  end

  // ****************************************************************
  // Freeze capture and output selection.
  // ****************************************************************
  logic [N_DO-1:0]    frzDout_ff;
  logic [N_TP*8-1:0]  frzDuty_ff;
  logic [N_AO*16-1:0] frzAout_ff;
  wire  logic enterOff = scanEnd && mode_ff == MOSC_RUN && nxt_mode == MOSC_OFFLINE;

  // Capture last active values as OFFLINE begins.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frzDout_ff <= '0;
      frzDuty_ff <= '0;
      frzAout_ff <= '0;
    end else if (enterOff) begin  // R19
      frzDout_ff <= fbDout;
      frzDuty_ff <= fbDuty;
      frzAout_ff <= fbAout;
    end
  end

  logic [N_DO-1:0]    nxt_dout;
  logic [N_TP*8-1:0]  nxt_duty;
  logic [N_ST-1:0]    nxt_fwd;
  logic [N_ST-1:0]    nxt_rev;
  logic [N_AO*16-1:0] nxt_aout;

  // Output value per mode.
  always_comb begin
    case (mode_ff)
      MOSC_RUN: begin
        nxt_dout = fbDout;  // R1
        nxt_duty = fbDuty;
        nxt_fwd  = fbFwd;
        nxt_rev  = fbRev;
        nxt_aout = fbAout;
      end
      MOSC_OFFLINE: begin
        nxt_dout = frzDout_ff;  // R6 R13
        nxt_duty = frzDuty_ff;  // R14
        nxt_fwd  = '0;          // R15
        nxt_rev  = '0;
        nxt_aout = frzAout_ff;  // R16
      end
      default: begin
        nxt_dout = '0;                        // R3 R9
        nxt_duty = {N_TP{`MOSC_DUTY_OFF}};    // R10
        nxt_fwd  = '0;                        // R11
        nxt_rev  = '0;
        nxt_aout = {N_AO{`MOSC_AOUT_OFF}};    // R12
      end
    endcase
  end

  // Output registers.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dout    <= '0;
      tpDuty  <= '0;
      stepFwd <= '0;
      stepRev <= '0;
      aout    <= '0;
    end else begin
      dout    <= nxt_dout;
      tpDuty  <= nxt_duty;
      stepFwd <= nxt_fwd;
      stepRev <= nxt_rev;
      aout    <= nxt_aout;
    end
  end

  // ****************************************************************
  // Mode permissions.
  // ****************************************************************
  assign modeOut      = mode_ff;
  assign ioScanEn     = 1'b1;                                         // R3 R6
  assign diagEn       = 1'b1;                                         // R8
  assign fbExecEn     = (mode_ff == MOSC_RUN);                        // R1
  assign forceLed     = forceActive && (mode_ff != MOSC_PROGRAM);     // R2 R5 R7
  assign fwDownloadEn = (mode_ff == MOSC_PROGRAM) && ctrl_ff[`MOSC_CTRL_FWDL];  // R4
  assign aiCalEn      = (mode_ff != MOSC_RUN) && ctrl_ff[`MOSC_CTRL_CALAI];     // R7
  assign aoCalEn      = (mode_ff == MOSC_PROGRAM) && ctrl_ff[`MOSC_CTRL_CALAO]; // R7

  // ****************************************************************
  // Checks.
  // ****************************************************************
  chk_prog_off: assert property (@(posedge ref_clk) disable iff (reset)  // R3
    mode_ff == MOSC_PROGRAM |=> (dout == '0 && aout == '0 && tpDuty == '0))
    else $error("Outputs not off in program mode.");
  chk_offline_entry: assert property (@(posedge ref_clk) disable iff (reset)  // R17
    $changed(mode_ff) && mode_ff == MOSC_OFFLINE |-> $past(mode_ff) == MOSC_RUN)
    else $error("Offline entered from a mode other than run.");
  chk_offline_hold: assert property (@(posedge ref_clk) disable iff (reset)  // R13
    mode_ff == MOSC_OFFLINE && $past(mode_ff) == MOSC_OFFLINE |=> $stable(dout) && $stable(aout))
    else $error("Frozen outputs moved.");
  chk_step_off: assert property (@(posedge ref_clk) disable iff (reset)  // R15
    mode_ff != MOSC_RUN |=> (stepFwd == '0 && stepRev == '0))
    else $error("Step drive active outside run.");
  chk_mode_boundary: assert property (@(posedge ref_clk) disable iff (reset)  // R19
    !$past(scanEnd) |-> $stable(mode_ff))
    else $error("Mode changed off a scan boundary.");
  chk_switch_lock: assert property (@(posedge ref_clk) disable iff (reset)  // R18
    scanEnd && swSync_ff == `MOSC_SW_PROGLOCK |=> mode_ff == MOSC_PROGRAM)
    else $error("Switch lock not obeyed.");
  chk_force_led: assert property (@(posedge ref_clk) disable iff (reset)  // R5
    mode_ff == MOSC_PROGRAM |-> !forceLed)
    else $error("Force LED shown in program mode.");
  chk_run_follow: assert property (@(posedge ref_clk) disable iff (reset)  // R1
    mode_ff == MOSC_RUN ##1 mode_ff == MOSC_RUN |-> dout == $past(fbDout))
    else $error("Run outputs do not follow block results.");
  chk_ao_cal: assert property (@(posedge ref_clk) disable iff (reset)  // R7
    mode_ff == MOSC_OFFLINE |-> !aoCalEn)
    else $error("Output calibration allowed offline.");
  chk_fw_dl: assert property (@(posedge ref_clk) disable iff (reset)  // R4
    fwDownloadEn |-> mode_ff == MOSC_PROGRAM)
    else $error("Firmware download outside program.");
  chk_frz_duty: assert property (@(posedge ref_clk) disable iff (reset)  // R14
    mode_ff == MOSC_OFFLINE && $past(mode_ff) == MOSC_OFFLINE |=> $stable(tpDuty))
    else $error("Frozen duty moved.");
  chk_frz_capture: assert property (@(posedge ref_clk) disable iff (reset)  // R16
    enterOff |-> ##2 (aout == $past(fbAout, 2) && dout == $past(fbDout, 2)))
    else $error("Frozen values differ from the entry scan.");
  chk_run_led: assert property (@(posedge ref_clk) disable iff (reset)  // R2
    mode_ff == MOSC_RUN && forceActive |-> forceLed)
    else $error("Force LED hidden in run mode.");
  chk_offline_ai: assert property (@(posedge ref_clk) disable iff (reset)  // R7
    mode_ff == MOSC_OFFLINE && ctrl_ff[`MOSC_CTRL_CALAI] |-> aiCalEn)
    else $error("Input calibration refused offline.");

endmodule // mosc_mode_ctrl
`default_nettype wire

// ### src/mosc_pkg.sv
/*
  Types for the controller mode and output state block.
  Assumes the constants header is on the include path.
*/
`include "mosc_regs.svh"
package mosc_pkg;
  // Operating mode of the controller.
  typedef enum logic [1:0] {
    MOSC_PROGRAM,
    MOSC_RUN,
    MOSC_OFFLINE
  } mosc_mode_t;
endpackage

// ### src/mosc_regs.svh
/*
  Register offsets, field positions, reset values and mode codes for the
  controller mode and output state block.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef MOSC_REGS_SVH
`define MOSC_REGS_SVH

// ****************************************************************
// Register byte offsets on the APB bus.
// ****************************************************************
`define MOSC_CTRL_OFS    12'h000
`define MOSC_STATUS_OFS  12'h004
`define MOSC_DOUT_OFS    12'h008
`define MOSC_TPDUTY_OFS  12'h00C
`define MOSC_STEP_OFS    12'h010
`define MOSC_AOUT_OFS    12'h014

// ****************************************************************
// Field positions.
// ****************************************************************
`define MOSC_CTRL_REQ_LSB  0
`define MOSC_CTRL_REQ_MSB  1
`define MOSC_CTRL_FWDL     2
`define MOSC_CTRL_CALAI    3
`define MOSC_CTRL_CALAO    4

// ****************************************************************
// Mode codes as seen by software and the switch.
// ****************************************************************
`define MOSC_CODE_PROG     2'h0
`define MOSC_CODE_RUN      2'h1
`define MOSC_CODE_OFFLINE  2'h2
`define MOSC_SW_RUNLOCK    2'h0
`define MOSC_SW_RUNPROG    2'h1
`define MOSC_SW_PROGLOCK   2'h2

// ****************************************************************
// Reset values and off-state levels.
// ****************************************************************
`define MOSC_CTRL_RST    32'h0000_0000
`define MOSC_DUTY_OFF    8'h00
`define MOSC_AOUT_OFF    16'h0000

`endif

// ### tb/mosc_io_model.sv
/*
  Behavioural model of the step I/O modules that take the block's stepFwd and stepRev lines.
  Assumes the outputs are registered on ref_clk and settle between edges.
*/
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// I/O module model.
// ****************************************************************
module mosc_io_model (
  input  wire logic        ref_clk,    // Clock.
  input  wire logic        reset,      // Synchronous reset, high.
  input  wire logic [1:0]  stepFwd,    // Step forward lines.
  input  wire logic [1:0]  stepRev,    // Step reverse lines.
  output logic             pairFault   // Both lines of a pair seen high.
);
  // A motor driven both ways at once would be damaged, so latch that case.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pairFault <= 1'b0;
    end else if ((stepFwd & stepRev) != 2'h0) begin
      pairFault <= 1'b1;
    end
  end
endmodule // mosc_io_model
`default_nettype wire

// ### tb/tb_mosc_mode_ctrl.sv
/*
  Self-checking bench for the mode and output state block.
  Assumes the default channel counts and a zero wait state APB slave.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mosc_regs.svh"
module tb_mosc_mode_ctrl;
  import mosc_pkg::*;
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, scanEnd = 0, forceActive = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, fbDuty = 32'h8040_20FF, rd;
  logic pready, pslverr, err, ioScanEn, fbExecEn, diagEn, forceLed, fwDownloadEn, aiCalEn, aoCalEn, pairFault;
  logic [1:0] modeSwitch = `MOSC_SW_RUNPROG, fbFwd = 2'h1, fbRev = 2'h2, stepFwd, stepRev;
  logic [7:0] fbDout = 8'hA5, dout;
  logic [31:0] tpDuty;
  logic [63:0] fbAout = 64'h1234_5678_9ABC_DEF0, aout;
  mosc_pkg::mosc_mode_t modeOut;
  int bad_count = 0, compares = 0;
  mosc_mode_ctrl mosc_mode_ctrl_i (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modeSwitch(modeSwitch), .scanEnd(scanEnd), .forceActive(forceActive), .fbDout(fbDout), .fbDuty(fbDuty),
    .fbFwd(fbFwd), .fbRev(fbRev), .fbAout(fbAout), .modeOut(modeOut), .ioScanEn(ioScanEn), .fbExecEn(fbExecEn),
    .diagEn(diagEn), .forceLed(forceLed), .fwDownloadEn(fwDownloadEn), .aiCalEn(aiCalEn), .aoCalEn(aoCalEn),
    .dout(dout), .tpDuty(tpDuty), .stepFwd(stepFwd), .stepRev(stepRev), .aout(aout));
  mosc_io_model mosc_io_model_i (.ref_clk(ref_clk), .reset(reset), .stepFwd(stepFwd), .stepRev(stepRev),
    .pairFault(pairFault));
  // ****************************************************************
  // Clock and shared tasks.
  // ****************************************************************
  // Clock at 125 MHz.
  always #4 ref_clk = ~ref_clk;
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Compares a seen value against the expected one.
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // One APB transfer; the answer is taken as sampled at the completing edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        break;
      end
      if (i == 19) begin bad_count++; stop_test(); end
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // One scan boundary pulse, then time for the outputs to follow.
  task automatic scan();
    @(posedge ref_clk) scanEnd <= 1'b1;
    @(posedge ref_clk) scanEnd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Checks every output channel against one expected set.
  task automatic outs(input logic [7:0] d, input logic [31:0] t, input logic [1:0] f, r, input logic [63:0] a);
    check("dout", 64'(dout), 64'(d));
    check("tpDuty", 64'(tpDuty), 64'(t));
    check("stepFwd", 64'(stepFwd), 64'(f));
    check("stepRev", 64'(stepRev), 64'(r));
    check("aout", aout, a);
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // PROGRAM holds outputs off, hides forces, allows downloads, refuses OFFLINE.
  task automatic t_program();
    outs(8'h00, 32'h0, 2'h0, 2'h0, 64'h0);
    apb(1'b1, `MOSC_CTRL_OFS, 32'h0000_001E);
    apb(1'b0, `MOSC_CTRL_OFS, 32'h0);
    check("ctrl", 64'(rd), 64'h1E);
    scan();
    check("modeOut", 64'(modeOut), 64'(MOSC_PROGRAM));
    check("forceLed", 64'(forceLed), 64'h0);
    check("fwDownloadEn", 64'(fwDownloadEn), 64'h1);
    check("aoCalEn", 64'(aoCalEn), 64'h1);
    check("fbExecEn", 64'(fbExecEn), 64'h0);
    check("ioScanEn", 64'(ioScanEn), 64'h1);
    outs(8'h00, 32'h0, 2'h0, 2'h0, 64'h0);
  endtask
  // RUN is taken only at a scan boundary and then outputs follow the blocks.
  task automatic t_run();
    apb(1'b1, `MOSC_CTRL_OFS, 32'h0000_000D);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check("modeOut", 64'(modeOut), 64'(MOSC_PROGRAM));
    scan();
    check("modeOut", 64'(modeOut), 64'(MOSC_RUN));
    check("fbExecEn", 64'(fbExecEn), 64'h1);
    check("forceLed", 64'(forceLed), 64'h1);
    check("fwDownloadEn", 64'(fwDownloadEn), 64'h0);
    outs(fbDout, fbDuty, fbFwd, fbRev, fbAout);
  endtask
  // OFFLINE freezes the values of the entry scan while the blocks move on.
  task automatic t_offline();
    apb(1'b1, `MOSC_CTRL_OFS, 32'h0000_001A);
    scan();
    fbDout <= 8'h5A; fbDuty <= 32'h0102_0304; fbAout <= 64'hFFFF_0000_1111_2222; fbFwd <= 2'h2; fbRev <= 2'h1;
    scan();
    check("modeOut", 64'(modeOut), 64'(MOSC_OFFLINE));
    outs(8'hA5, 32'h8040_20FF, 2'h0, 2'h0, 64'h1234_5678_9ABC_DEF0);
    check("aiCalEn", 64'(aiCalEn), 64'h1);
    check("aoCalEn", 64'(aoCalEn), 64'h0);
    check("forceLed", 64'(forceLed), 64'h1);
    check("diagEn", 64'(diagEn), 64'h1);
    apb(1'b0, `MOSC_STATUS_OFS, 32'h0);
    check("status", 64'(rd), 64'h56);
  endtask
  // The switch wins over the register request in both locked positions.
  task automatic t_switch();
    modeSwitch <= `MOSC_SW_PROGLOCK;
    apb(1'b1, `MOSC_CTRL_OFS, 32'h0000_0001);
    scan();
    check("modeOut", 64'(modeOut), 64'(MOSC_PROGRAM));
    modeSwitch <= `MOSC_SW_RUNLOCK;
    apb(1'b1, `MOSC_CTRL_OFS, 32'h0000_0000);
    scan();
    check("modeOut", 64'(modeOut), 64'(MOSC_RUN));
    outs(8'h5A, 32'h0102_0304, 2'h2, 2'h1, 64'hFFFF_0000_1111_2222);
    apb(1'b0, 12'h0FC, 32'h0);
    check("pslverr", 64'(err), 64'h1);
    check("unmapped", 64'(rd), 64'h0);
    check("pairFault", 64'(pairFault), 64'h0);
  endtask
  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  // Cuts a hang short.
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
  // Reset for two cycles, then the scenarios in order.
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check("modeOut", 64'(modeOut), 64'(MOSC_PROGRAM));
    t_program();
    t_run();
    t_offline();
    t_switch();
    stop_test();
  end
endmodule // tb_mosc_mode_ctrl
`default_nettype wire
